// ===== logic/cdp_pkg.sv
package cdp_pkg;

  // ******************************************************************
  // Widths and sizes
  // ******************************************************************
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned ADDR_LOW_W  = 18;
  localparam int unsigned ADDR_HIGH_W = 4;
  localparam int unsigned ADDR_W      = ADDR_LOW_W + ADDR_HIGH_W;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned BIT_CNT_W   = 3;

  // ******************************************************************
  // Field positions and reset values
  // ******************************************************************
  localparam int unsigned STATUS_BIT   = 7;
  localparam logic [6:0]  STATUS_FILL  = 7'h7f;
  localparam logic [ADDR_W-1:0] ADDR_RST = 22'h000000;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  // ******************************************************************
  // Configuration modes, one-hot
  // ******************************************************************
  typedef enum logic [4:0] {
    CDP_MODE_SLAVE_SER  = 5'h01,
    CDP_MODE_MASTER_SER = 5'h02,
    CDP_MODE_ASYNC_PER  = 5'h04,
    CDP_MODE_MASTER_PAR = 5'h08,
    CDP_MODE_EXPRESS    = 5'h10
  } cdp_mode_t;

  // Port sequencing states, one-hot
  typedef enum logic [2:0] {
    CDP_ST_IDLE     = 3'h1,
    CDP_ST_LOAD     = 3'h2,
    CDP_ST_RELEASED = 3'h4
  } cdp_state_t;

  // ******************************************************************
  // Pin sample bundle carried through the synchroniser
  // ******************************************************************
  typedef struct packed {
    logic       select_low_active;
    logic       select_high_active;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       config_clock;
    logic [7:1] byte_hi;
    logic       data0;
  } cdp_pins_t;

endpackage : cdp_pkg

// ===== logic/cdp_fifo.sv
module cdp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  // Depth must be a power of two so the pointers wrap naturally
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("cdp_fifo: DEPTH must be a power of two, at least 2");
  end
  if (WIDTH < 1) begin : g_width_check
    $error("cdp_fifo: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W:0]   wr_ptr_r;
  logic [PTR_W:0]   rd_ptr_r;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  // ******************************************************************
  // Flags from the extra pointer bit
  // ******************************************************************
  assign empty       = (wr_ptr_r == rd_ptr_r);
  assign full        = (wr_ptr_r[PTR_W] != rd_ptr_r[PTR_W]) &&
                       (wr_ptr_r[PTR_W-1:0] == rd_ptr_r[PTR_W-1:0]);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_r[rd_ptr_r[PTR_W-1:0]];
  assign push        = ce_i && in_valid_i && !full;
  assign pop         = ce_i && out_ready_i && !empty;

  // Storage write
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[PTR_W-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule // cdp_fifo

// ===== logic/cdp_config_port.sv
// Summary of operation
// - In asynchronous peripheral mode the port is selected only while select_low_active is low and select_high_active is high.
// - While selected, a falling edge of the write strobe loads the byte bus into the internal data buffer.
// - While selected with read strobe low, bit 7 of the byte bus shows ready (high) or busy (low) and bits 0 to 6 are driven high.
// - When write and read strobes are low together the write takes effect and the read is ignored.
// - In express mode select_high_active acts as the serial enable from the upstream device.
// - In master parallel mode an 18-bit address is driven to the external configuration memory.
// - The wide-address variant drives four more upper address bits, making 22 in all.
// - In master parallel and peripheral modes configuration data arrives as whole bytes on the byte bus.
// - In serial modes the serial input is sampled on every rising edge of config_clock.
// - In parallel modes the serial input pin serves as bit 0 of the byte bus.
// - In every mode but express the serial data is repeated on the serial output for a downstream device.
// - The serial output changes on a falling config_clock edge, one and a half periods after the bit was sampled.
// - In express mode the serial output instead carries an enable for the next device in the chain.
// - Once configuration is done, all pins of the port are released to user logic.
module cdp_config_port #(
  parameter bit          WIDE_ADDR  = 1'b1,
  parameter int unsigned FIFO_DEPTH = cdp_pkg::FIFO_DEPTH
) (
  input  wire logic                                core_clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                ce_i,
  // Mode and end of configuration from the sequencer
  input  wire cdp_pkg::cdp_mode_t                  mode_i,
  input  wire logic                                config_done_i,
  // Peripheral strobes and selects (pins)
  input  wire logic                                select_low_active_i,
  input  wire logic                                select_high_active_i,
  input  wire logic                                write_strobe_n_i,
  input  wire logic                                read_strobe_n_i,
  input  wire logic                                config_clock_i,
  // Byte bus bits 7..1 (two-way pins)
  input  wire logic [7:1]                          config_byte_bus_i,
  output logic [7:1]                               config_byte_bus_o,
  output logic                                     config_byte_bus_oe_n_o,
  // Serial input pin, also byte bus bit 0 (two-way pin)
  input  wire logic                                data0_i,
  output logic                                     data0_o,
  output logic                                     data0_oe_n_o,
  // Serial output pin
  output logic                                     serial_out_o,
  output logic                                     serial_out_oe_n_o,
  // Memory address pins
  output logic [cdp_pkg::ADDR_LOW_W-1:0]           memory_address_low_o,
  output logic                                     memory_address_low_oe_n_o,
  output logic [cdp_pkg::ADDR_HIGH_W-1:0]          memory_address_high_o,
  output logic                                     memory_address_high_oe_n_o,
  // Byte stream towards the configuration memory loader
  output logic                                     cfg_valid_o,
  input  wire logic                                cfg_ready_i,
  output logic [cdp_pkg::BYTE_W-1:0]               cfg_byte_o,
  // Status
  output logic                                     overflow_o,
  output logic                                     pins_released_o
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  if (FIFO_DEPTH < 2) begin : g_param_check
    $error("cdp_config_port: FIFO_DEPTH must be at least 2");
  end

  cdp_pkg::cdp_pins_t                 pins_raw;
  cdp_pkg::cdp_pins_t                 sync1_r;
  cdp_pkg::cdp_pins_t                 sync2_r;
  cdp_pkg::cdp_pins_t                 prev_r;
  cdp_pkg::cdp_state_t                state_r;
  cdp_pkg::cdp_state_t                state_nxt;
  cdp_pkg::cdp_mode_t                 mode_r;
  logic                               loading;
  logic                               selected;
  logic                               write_fall;
  logic                               read_active;
  logic                               clk_rise;
  logic                               clk_fall;
  logic [cdp_pkg::BYTE_W-1:0]         bus_byte;
  logic [cdp_pkg::BYTE_W-1:0]         shift_r;
  logic [cdp_pkg::BIT_CNT_W-1:0]      bit_cnt_r;
  logic                               bit_early_r;
  logic                               bit_late_r;
  logic [cdp_pkg::BYTE_W-1:0]         hold_r;
  logic                               hold_valid_r;
  logic                               new_byte;
  logic [cdp_pkg::BYTE_W-1:0]         new_byte_data;
  logic                               fifo_in_ready;
  logic                               fifo_out_valid;
  logic                               fifo_out_ready;
  logic [cdp_pkg::BYTE_W-1:0]         fifo_out_data;
  logic [cdp_pkg::ADDR_W-1:0]         addr_r;
  logic                               mode_serial;
  logic                               mode_par_bytes;

  // ******************************************************************
  // Pin synchroniser, two stages, then one edge-detect stage
  // ******************************************************************
  assign pins_raw = '{
    select_low_active:  select_low_active_i,
    select_high_active: select_high_active_i,
    write_strobe_n:     write_strobe_n_i,
    read_strobe_n:      read_strobe_n_i,
    config_clock:       config_clock_i,
    byte_hi:            config_byte_bus_i,
    data0:              data0_i
  };

  // Idle pin levels at reset keep the edge detectors quiet
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_r <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 7'h00, 1'b0};
      sync2_r <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 7'h00, 1'b0};
      prev_r  <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 7'h00, 1'b0};
    end else if (ce_i) begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ******************************************************************
  // Decoded pin events
  // ******************************************************************
  assign loading        = (state_r == cdp_pkg::CDP_ST_LOAD);
  assign mode_serial    = (mode_r == cdp_pkg::CDP_MODE_SLAVE_SER) ||
                          (mode_r == cdp_pkg::CDP_MODE_MASTER_SER);
  assign mode_par_bytes = (mode_r == cdp_pkg::CDP_MODE_MASTER_PAR) ||
                          (mode_r == cdp_pkg::CDP_MODE_EXPRESS);
  assign selected       = !sync2_r.select_low_active && sync2_r.select_high_active;
  assign write_fall     = selected && !sync2_r.write_strobe_n && prev_r.write_strobe_n;
  assign read_active    = selected && !sync2_r.read_strobe_n &&
                          sync2_r.write_strobe_n;
  assign clk_rise       = sync2_r.config_clock && !prev_r.config_clock;
  assign clk_fall       = !sync2_r.config_clock && prev_r.config_clock;
  assign bus_byte       = {sync2_r.byte_hi, sync2_r.data0};

  // ******************************************************************
  // Port sequencing
  // ******************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cdp_pkg::CDP_ST_IDLE: begin
        state_nxt = cdp_pkg::CDP_ST_LOAD;
      end
      cdp_pkg::CDP_ST_LOAD: begin
        if (config_done_i) begin
          state_nxt = cdp_pkg::CDP_ST_RELEASED;
        end
      end
      cdp_pkg::CDP_ST_RELEASED: begin
        state_nxt = cdp_pkg::CDP_ST_RELEASED;
      end
      default: begin
        state_nxt = cdp_pkg::CDP_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= cdp_pkg::CDP_ST_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // Mode is caught once, on the first enabled cycle after reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_r <= cdp_pkg::CDP_MODE_SLAVE_SER;
    end else if (ce_i && state_r == cdp_pkg::CDP_ST_IDLE) begin
      mode_r <= mode_i;
    end
  end

  // ******************************************************************
  // Serial assembly, MSB first
  // ******************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shift_r   <= cdp_pkg::BYTE_RST;
      bit_cnt_r <= '0;
    end else if (ce_i && loading && mode_serial && clk_rise) begin
      shift_r   <= {shift_r[cdp_pkg::BYTE_W-2:0], sync2_r.data0};
      bit_cnt_r <= bit_cnt_r + 1'b1;
    end
  end

  // ******************************************************************
  // Byte sources into the internal data buffer
  // ******************************************************************
  always_comb begin
    new_byte      = 1'b0;
    new_byte_data = bus_byte;
    if (loading) begin
      case (mode_r)
        cdp_pkg::CDP_MODE_ASYNC_PER: begin
          new_byte = write_fall;
        end
        cdp_pkg::CDP_MODE_MASTER_PAR: begin
          new_byte = clk_rise;
        end
        cdp_pkg::CDP_MODE_EXPRESS: begin
          new_byte = clk_rise && sync2_r.select_high_active;
        end
        cdp_pkg::CDP_MODE_SLAVE_SER,
        cdp_pkg::CDP_MODE_MASTER_SER: begin
          new_byte      = clk_rise && (bit_cnt_r == cdp_pkg::BIT_CNT_LAST);
          new_byte_data = {shift_r[cdp_pkg::BYTE_W-2:0], sync2_r.data0};
        end
        default: begin
          new_byte = 1'b0;
        end
      endcase
    end
  end

  // Internal data buffer; it stays full until the FIFO takes it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hold_r       <= cdp_pkg::BYTE_RST;
      hold_valid_r <= 1'b0;
    end else if (ce_i) begin
      if (new_byte && !hold_valid_r) begin
        hold_r       <= new_byte_data;
        hold_valid_r <= 1'b1;
      end else if (hold_valid_r && fifo_in_ready) begin
        hold_valid_r <= 1'b0;
      end
    end
  end

  // A byte arriving while the buffer is still full is lost; flag it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      overflow_o <= 1'b0;
    end else if (ce_i && new_byte && hold_valid_r) begin
      overflow_o <= 1'b1;
    end
  end

  // ******************************************************************
  // Byte FIFO towards the loader
  // ******************************************************************
  cdp_fifo #(
    .WIDTH (cdp_pkg::BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (hold_valid_r),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (hold_r),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  assign fifo_out_ready = !cfg_valid_o || cfg_ready_i;

  // Output register so the stream leaves from flip-flops
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cfg_valid_o <= 1'b0;
      cfg_byte_o  <= cdp_pkg::BYTE_RST;
    end else if (ce_i && fifo_out_ready) begin
      cfg_valid_o <= fifo_out_valid;
      if (fifo_out_valid) begin
        cfg_byte_o <= fifo_out_data;
      end
    end
  end

  // ******************************************************************
  // Status read on the byte bus
  // ******************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      config_byte_bus_o      <= 7'h7f;
      config_byte_bus_oe_n_o <= 1'b1;
      data0_o                <= 1'b1;
      data0_oe_n_o           <= 1'b1;
    end else if (ce_i) begin
      config_byte_bus_o[cdp_pkg::STATUS_BIT] <= !hold_valid_r && !new_byte;
      config_byte_bus_o[6:1]                 <= cdp_pkg::STATUS_FILL[6:1];
      data0_o                                <= cdp_pkg::STATUS_FILL[0];
      if (loading && mode_r == cdp_pkg::CDP_MODE_ASYNC_PER && read_active) begin
        config_byte_bus_oe_n_o <= 1'b0;
        data0_oe_n_o           <= 1'b0;
      end else begin
        config_byte_bus_oe_n_o <= 1'b1;
        data0_oe_n_o           <= 1'b1;
      end
    end
  end

  // ******************************************************************
  // Serial repeat pipeline: sampled on a rise, shown on the next-but-one fall
  // ******************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bit_early_r <= 1'b0;
      bit_late_r  <= 1'b0;
    end else if (ce_i && loading && clk_rise) begin
      bit_early_r <= sync2_r.data0;
      bit_late_r  <= bit_early_r;
    end
  end

  // Serial output: repeated data, or chain enable in express mode
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      serial_out_o      <= 1'b1;
      serial_out_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      if (!loading) begin
        serial_out_oe_n_o <= 1'b1;
      end else if (mode_r == cdp_pkg::CDP_MODE_EXPRESS) begin
        serial_out_oe_n_o <= 1'b0;
        serial_out_o      <= config_done_i;
      end else begin
        serial_out_oe_n_o <= 1'b0;
        if (clk_fall) begin
          serial_out_o <= bit_late_r;
        end
      end
    end
  end

  // ******************************************************************
  // Master parallel address counter
  // ******************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_r <= cdp_pkg::ADDR_RST;
    end else if (ce_i && loading && mode_r == cdp_pkg::CDP_MODE_MASTER_PAR && clk_rise) begin
      addr_r <= addr_r + 1'b1;
    end
  end

  // Address pins, driven only while loading in master parallel mode
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      memory_address_low_o       <= '0;
      memory_address_high_o      <= '0;
      memory_address_low_oe_n_o  <= 1'b1;
      memory_address_high_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      memory_address_low_o  <= addr_r[cdp_pkg::ADDR_LOW_W-1:0];
      memory_address_high_o <= WIDE_ADDR ? addr_r[cdp_pkg::ADDR_W-1:cdp_pkg::ADDR_LOW_W]
                                         : '0;
      memory_address_low_oe_n_o  <= !(loading && mode_r == cdp_pkg::CDP_MODE_MASTER_PAR);
      memory_address_high_oe_n_o <= !(WIDE_ADDR && loading &&
                                      mode_r == cdp_pkg::CDP_MODE_MASTER_PAR);
    end
  end

  // Handover flag for user logic
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pins_released_o <= 1'b0;
    end else if (ce_i) begin
      pins_released_o <= (state_r == cdp_pkg::CDP_ST_RELEASED);
    end
  end

  // Unused mode flag kept meaningful for master parallel and express modes
  logic unused_par;
  assign unused_par = mode_par_bytes;

endmodule // cdp_config_port

// ===== sim/cdp_checker.sv
module cdp_checker (
  input wire logic               core_clk_i,
  input wire logic               rst_i,
  input wire cdp_pkg::cdp_mode_t mode_i,
  input wire logic               config_done_i,
  input wire logic               select_low_active_i,
  input wire logic               write_strobe_n_i,
  input wire logic               read_strobe_n_i,
  input wire logic [7:1]         config_byte_bus_o,
  input wire logic               config_byte_bus_oe_n_o,
  input wire logic               data0_o,
  input wire logic               serial_out_o,
  input wire logic               serial_out_oe_n_o,
  input wire logic [17:0]        memory_address_low_o,
  input wire logic               memory_address_low_oe_n_o,
  input wire logic [3:0]         memory_address_high_o,
  input wire logic               memory_address_high_oe_n_o,
  input wire logic               pins_released_o
);
  logic [21:0] addr;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // Full memory address as one word
  assign addr = {memory_address_high_o, memory_address_low_o};
  // ********************
  // Port properties
  // ********************
  // ********************
  sequence s_both_low; (!write_strobe_n_i && !read_strobe_n_i) [*5]; endsequence
  property p_rel; pins_released_o |-> &{config_byte_bus_oe_n_o, serial_out_oe_n_o, memory_address_low_oe_n_o}; endproperty
  a_rel: assert property (p_rel) else $error("pin driven after release");
  property p_fill; !config_byte_bus_oe_n_o |-> config_byte_bus_o[6:1] == 6'h3f && data0_o; endproperty
  a_fill: assert property (p_fill) else $error("status fill bits not high");
  property p_mode; !config_byte_bus_oe_n_o |-> mode_i == cdp_pkg::CDP_MODE_ASYNC_PER; endproperty
  a_mode: assert property (p_mode) else $error("status driven outside peripheral mode");
  property p_desel; select_low_active_i [*5] |-> config_byte_bus_oe_n_o; endproperty
  a_desel: assert property (p_desel) else $error("status driven while deselected");
  property p_wrrd; s_both_low |-> config_byte_bus_oe_n_o; endproperty
  a_wrrd: assert property (p_wrrd) else $error("read served during write");
  property p_ahi; !memory_address_high_oe_n_o |-> !memory_address_low_oe_n_o; endproperty
  a_ahi: assert property (p_ahi) else $error("upper address without lower");
  property p_alo; !memory_address_low_oe_n_o |-> mode_i == cdp_pkg::CDP_MODE_MASTER_PAR; endproperty
  a_alo: assert property (p_alo) else $error("address driven outside master parallel");
  property p_ainc; addr != $past(addr) |-> addr == $past(addr) + 22'h000001; endproperty
  a_ainc: assert property (p_ainc) else $error("address did not step by one");
  property p_expr;
    mode_i == cdp_pkg::CDP_MODE_EXPRESS && !serial_out_oe_n_o && !pins_released_o |=> serial_out_o == $past(config_done_i);
  endproperty
  a_expr: assert property (p_expr) else $error("chain enable wrong");
endmodule // cdp_checker

bind cdp_config_port cdp_checker u_chk (.*);

// ===== sim/cdp_far_model.sv
module cdp_far_model (
  input  wire logic        run_i,
  input  wire logic [7:0]  sbyte_i,
  input  wire logic [21:0] addr_i,
  output logic             config_clock_o,
  output logic [7:0]       mem_o,
  output logic             sdat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] idx;
  initial idx = 4'h0;
  initial config_clock_o = 1'b0;
  // Link clock of 80 ns, only within a frame
  always begin
    wait (run_i);
    #43 config_clock_o = 1'b1;
    #37 config_clock_o = 1'b0;
  end
  // Bit index moves on the fall, so data is steady at each rise
  always @(negedge config_clock_o or negedge run_i) begin
    if (!run_i) idx <= 4'h0;
    else idx <= idx + 4'h1;
  end
  // Serial bits MSB first; outside a frame the inverse shows
  assign sdat_o = sbyte_i[3'h7 - idx[2:0]] ^ !run_i;
  // Memory answers every address at once
  assign mem_o = addr_i[7:0] ^ 8'h5b;
endmodule // cdp_far_model

// ===== sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               core_clk_i, rst_i, ce_i, config_done_i, select_low_active_i, select_high_active_i;
  logic               write_strobe_n_i, read_strobe_n_i, config_clock_i, data0_i, data0_o, data0_oe_n_o;
  logic               serial_out_o, serial_out_oe_n_o, memory_address_low_oe_n_o, memory_address_high_oe_n_o;
  logic               cfg_valid_o, cfg_ready_i, overflow_o, pins_released_o, config_byte_bus_oe_n_o, sdat, run;
  logic [7:1]         config_byte_bus_i, config_byte_bus_o;
  logic [17:0]        memory_address_low_o;
  logic [3:0]         memory_address_high_o;
  logic [7:0]         cfg_byte_o, hd, mem, sb;
  logic [1:0]         src;
  cdp_pkg::cdp_mode_t mode_i;
  int                 n_errors, num_checks, cyc = 0, t;
  logic [7:0]         q[$];
  logic [15:0]        rows[4] = '{16'h1e1e, 16'hffff, 16'ha5a5, 16'h3c3c};
  cdp_config_port u_dut (.*);
  cdp_far_model u_far (.run_i(run), .sbyte_i(sb), .addr_i({memory_address_high_o, memory_address_low_o}),
                       .config_clock_o(config_clock_i), .mem_o(mem), .sdat_o(sdat));
  // Two-way byte bus: the port wins while its enables are low
  assign config_byte_bus_i = !config_byte_bus_oe_n_o ? config_byte_bus_o : (src == 2'h1) ? mem[7:1] : hd[7:1];
  assign data0_i = !data0_oe_n_o ? data0_o : (src == 2'h1) ? mem[0] : (src == 2'h2) ? sdat : hd[0];
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // Consumer collects bytes, and a ceiling cuts a hang short
  always @(posedge core_clk_i) begin
    if (cfg_valid_o && cfg_ready_i) q.push_back(cfg_byte_o);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  // ********************
  // Shared tasks
  // ********************
  task chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task cyc_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task rmode(input cdp_pkg::cdp_mode_t m, input logic [1:0] s);
    if (t > 0) $display("test %0d done", t);
    t++;
    rst_i = 1'b1;
    mode_i = m;
    src = s;
    config_done_i = 1'b0;
    cyc_n(2);
    rst_i = 1'b0;
    cyc_n(4);
    q.delete();
  endtask
  // Host write; the read strobe stays high except in the overlap case
  task hw(input logic [7:0] b, input logic r, input logic l);
    select_low_active_i = l;
    hd = b;
    write_strobe_n_i = 1'b0;
    read_strobe_n_i = r;
    cyc_n(6);
    write_strobe_n_i = 1'b1;
    read_strobe_n_i = 1'b1;
    cyc_n(8);
  endtask
  task hr(input logic [7:0] e);
    read_strobe_n_i = 1'b0;
    cyc_n(5);
    chk({config_byte_bus_oe_n_o, config_byte_bus_o, data0_o}, {1'b0, e});
    read_strobe_n_i = 1'b1;
    cyc_n(5);
  endtask
  initial begin
    {ce_i, rst_i, select_high_active_i, write_strobe_n_i, read_strobe_n_i, cfg_ready_i} = 6'h3f;
    {config_done_i, select_low_active_i, run, hd, src, n_errors, num_checks, t} = '0;
    mode_i = cdp_pkg::CDP_MODE_ASYNC_PER;
    sb = 8'hc6;
    cyc_n(2);
    chk({pins_released_o, cfg_valid_o, overflow_o, serial_out_o, config_byte_bus_oe_n_o, config_byte_bus_o}, 12'h1ff);
    rmode(cdp_pkg::CDP_MODE_ASYNC_PER, 2'h0);
    foreach (rows[i]) begin
      hw(rows[i][15:8], 1'b1, 1'b0);
      hr(8'hff);
      chk(q.pop_front(), rows[i][7:0]);
    end
    hw(8'h81, 1'b0, 1'b0);
    chk(q.pop_front(), 8'h81);
    hw(8'h42, 1'b1, 1'b1);
    chk(q.size(), 0);
    // Stalled consumer: buffer fills, status busy, late bytes refused
    cfg_ready_i = 1'b0;
    for (int i = 0; i < 21; i++) hw(8'(i+1), 1'b1, 1'b0);
    hr(8'h7f);
    chk(overflow_o, 1'b1);
    cfg_ready_i = 1'b1;
    cyc_n(40);
    chk(q.pop_front(), 8'h01);
    // Master parallel: address walks the memory
    rmode(cdp_pkg::CDP_MODE_MASTER_PAR, 2'h1);
    run = 1'b1;
    repeat (4) @(posedge config_clock_i);
    @(negedge core_clk_i) run = 1'b0;
    cyc_n(20);
    for (int i = 0; i < 4; i++) chk(q[i], 8'(i) ^ 8'h5b);
    chk({memory_address_high_o, memory_address_low_o, memory_address_low_oe_n_o, memory_address_high_oe_n_o}, 24'h10);
    // Serial: bit taken on a rise, repeated on the later fall
    for (int m = 0; m < 2; m++) begin
      rmode(m ? cdp_pkg::CDP_MODE_MASTER_SER : cdp_pkg::CDP_MODE_SLAVE_SER, 2'h2);
      run = 1'b1;
      for (int k = 0; k < 8; k++) begin
        @(posedge config_clock_i);
        #20;
        if (k > 1) chk(serial_out_o, sb[9-k]);
      end
      @(negedge core_clk_i) run = 1'b0;
      cyc_n(20);
      chk(q.pop_front(), sb);
    end
    // Express: upstream enable gates bytes, then release
    rmode(cdp_pkg::CDP_MODE_EXPRESS, 2'h1);
    select_high_active_i = 1'b0;
    run = 1'b1;
    repeat (3) @(posedge config_clock_i);
    @(negedge core_clk_i) chk({q.size() != 0, serial_out_o}, 2'h0);
    select_high_active_i = 1'b1;
    repeat (3) @(posedge config_clock_i);
    @(negedge core_clk_i) run = 1'b0;
    cyc_n(20);
    chk(q.size() != 0, 1'b1);
    config_done_i = 1'b1;
    cyc_n(10);
    chk({pins_released_o, config_byte_bus_oe_n_o, data0_oe_n_o, serial_out_oe_n_o,
         memory_address_low_oe_n_o, memory_address_high_oe_n_o}, 6'h3f);
    $display("test %0d done", t);
    results();
  end
endmodule // tb_top
